//--- common/dcpc_pkg.sv
// shared constants and types of the up/down potentiometer host controller
// assumes a 100 MHz controller clock; all pin timings are derived from it
package dcpc_pkg;

	// ------------------------------------------------------------------
	// clock and widths
	// ------------------------------------------------------------------
	localparam int CLK_NS = 10;
	localparam int CNT_W  = 20;
	localparam int POS_W  = 7;

	typedef logic [CNT_W-1:0] dcpc_cnt_t;
	typedef logic [POS_W-1:0] dcpc_pos_t;

	// ------------------------------------------------------------------
	// tap counter range and shadow reset value
	// ------------------------------------------------------------------
	localparam dcpc_pos_t POS_MAX   = 7'h63;
	localparam dcpc_pos_t POS_RESET = 7'h00;

	// ------------------------------------------------------------------
	// pin timings in their own units
	// ------------------------------------------------------------------
	localparam int CI_NS    = 50;   // select to first strobe edge
	localparam int ID_NS    = 100;  // strobe high to direction change
	localparam int DI_NS    = 1000; // direction to strobe fall
	localparam int IL_NS    = 960;  // strobe low period
	localparam int IC_NS    = 1000; // step_idle_to_deselect_time
	localparam int CPHNS_NS = 100;  // deselect_time_without_save
	localparam int CPHS_MS  = 10;   // deselect_time_with_save
	localparam int IW_NS    = 5000; // step_to_wiper_settle_time
	localparam int PU_NS    = 5000; // powerup_to_wiper_stable

	// ------------------------------------------------------------------
	// least times rounded up to whole cycles
	// ------------------------------------------------------------------
	localparam dcpc_cnt_t CI_CYC    = CNT_W'((CI_NS + CLK_NS - 1) / CLK_NS);
	localparam dcpc_cnt_t ID_CYC    = CNT_W'((ID_NS + CLK_NS - 1) / CLK_NS);
	localparam dcpc_cnt_t DI_CYC    = CNT_W'((DI_NS + CLK_NS - 1) / CLK_NS);
	localparam dcpc_cnt_t IL_CYC    = CNT_W'((IL_NS + CLK_NS - 1) / CLK_NS);
	localparam dcpc_cnt_t IC_CYC    = CNT_W'((IC_NS + CLK_NS - 1) / CLK_NS);
	localparam dcpc_cnt_t CPHNS_CYC = CNT_W'((CPHNS_NS + CLK_NS - 1) / CLK_NS);
	localparam dcpc_cnt_t IW_CYC    = CNT_W'((IW_NS + CLK_NS - 1) / CLK_NS);
	localparam dcpc_cnt_t PU_CYC    = CNT_W'((PU_NS + CLK_NS - 1) / CLK_NS);
	localparam int        CPHS_CYC  = (CPHS_MS * 1000000 + CLK_NS - 1) / CLK_NS;

	// ------------------------------------------------------------------
	// host commands
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {OP_MOVE, OP_STORE, OP_RELEASE} dcpc_op_e;

endpackage

//--- common/dcpc_tmr_if.sv
// carrier between the controller sequencer and its wait timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface dcpc_tmr_if;
	logic                    load;  // start a new wait
	logic [dcpc_pkg::CNT_W-1:0] count; // wait length in cycles
	logic                    done;  // wait elapsed

	modport ctl (output load, output count, input done);
	modport tmr (input load, input count, output done);
endinterface

//--- core/dcpc_host.sv
// host-side sequencer that drives select, step strobe and direction pins
// assumes one 100 MHz clock and that the potentiometer needs no answer pins
`timescale 1ns/1ps
module dcpc_host #(
	parameter int STORE_HOLD_CYC = dcpc_pkg::CPHS_CYC
) (
	input  wire logic               i_mclk,
	input  wire logic               i_rst,
	input  wire logic               i_cmd_valid,
	input  wire dcpc_pkg::dcpc_op_e i_cmd_op,
	input  wire logic               i_cmd_up,
	input  wire dcpc_pkg::dcpc_pos_t i_cmd_steps,
	output logic                    o_cmd_ready,
	output logic                    o_done,
	output logic                    o_selected,
	output dcpc_pkg::dcpc_pos_t     o_position,
	output logic                    o_cs_n,
	output logic                    o_inc_n,
	output logic                    o_ud
);
	import dcpc_pkg::*;

	// ------------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------------
	if (STORE_HOLD_CYC < 1 || STORE_HOLD_CYC >= (1 << CNT_W))
		$error("STORE_HOLD_CYC must fit the wait timer");

	typedef enum {ST_RESET, ST_PWRUP, ST_IDLE, ST_SEL, ST_RISE, ST_DIR, ST_FALL,
		ST_SETTLE, ST_STRISE, ST_IC, ST_HOLD} dcpc_state_e;

	dcpc_state_e state;
	dcpc_state_e next_state;
	dcpc_state_e dispatch;
	dcpc_op_e    op;
	logic        up;
	dcpc_pos_t   steps_left;
	logic        accept;
	dcpc_tmr_if  tmr_bus ();

	dcpc_timer u_timer (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.tmr    (tmr_bus)
	);

	// ------------------------------------------------------------------
	// command intake
	// ------------------------------------------------------------------
	assign accept = i_cmd_valid && o_cmd_ready && (state == ST_IDLE);

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			op <= OP_MOVE;
			up <= 1'b0;
		end
		else if (accept)
		begin
			op <= i_cmd_op;
			up <= i_cmd_up;
		end
	end

	// where a command goes once the device is selected
	always_comb
	begin
		case (accept ? i_cmd_op : op)
			OP_STORE:   dispatch = ST_STRISE;
			OP_RELEASE: dispatch = ST_IC;
			default:    dispatch = ((accept ? i_cmd_steps : steps_left) == '0) ? ST_IDLE
				: ST_RISE;
		endcase
	end

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			ST_RESET:  next_state = ST_PWRUP;
			ST_PWRUP:  if (tmr_bus.done) next_state = ST_IDLE;
			ST_IDLE:
				if (accept)
				begin
					if (o_selected)
						next_state = dispatch;
					else if (i_cmd_op != OP_RELEASE)
						next_state = ST_SEL;
				end
			ST_SEL:    if (tmr_bus.done) next_state = dispatch;
			ST_RISE:   if (tmr_bus.done) next_state = ST_DIR;
			ST_DIR:    if (tmr_bus.done) next_state = ST_FALL;
			ST_FALL:   if (tmr_bus.done) next_state = (steps_left == '0) ? ST_SETTLE : ST_RISE;
			ST_SETTLE: if (tmr_bus.done) next_state = ST_IDLE;
			ST_STRISE: if (tmr_bus.done) next_state = ST_HOLD;
			ST_IC:     if (tmr_bus.done) next_state = ST_HOLD;
			ST_HOLD:   if (tmr_bus.done) next_state = ST_IDLE;
			default:   next_state = ST_RESET;
		endcase
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			state <= ST_RESET;
		else
			state <= next_state;
	end

	// ------------------------------------------------------------------
	// wait timer loads on every state change
	// ------------------------------------------------------------------
	always_comb
	begin
		tmr_bus.load = (next_state != state);
		case (next_state)
			ST_PWRUP:  tmr_bus.count = PU_CYC;
			ST_SEL:    tmr_bus.count = CI_CYC;
			ST_RISE:   tmr_bus.count = ID_CYC;
			ST_DIR:    tmr_bus.count = DI_CYC;
			ST_FALL:   tmr_bus.count = IL_CYC;
			ST_SETTLE: tmr_bus.count = IW_CYC;
			ST_STRISE: tmr_bus.count = IC_CYC;
			ST_IC:     tmr_bus.count = IC_CYC;
			// a store keeps the device busy far longer than a plain release
			ST_HOLD:   tmr_bus.count = (op == OP_STORE) ? CNT_W'(STORE_HOLD_CYC) : CPHNS_CYC;
			default:   tmr_bus.count = '0;
		endcase
	end

	// ------------------------------------------------------------------
	// pins, driven from flops one step ahead of the state
	// ------------------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			o_cs_n  <= 1'b1;
			o_inc_n <= 1'b1;
		end
		else
		begin
			// select falls only to start a session, rises only to end one
			o_cs_n <= (next_state == ST_PWRUP) || (next_state == ST_IDLE && !o_selected)
				|| (next_state == ST_HOLD) || (next_state == ST_RESET);
			// strobe parks low when idle so a release never needs a new edge
			o_inc_n <= (next_state == ST_PWRUP) || (next_state == ST_RESET)
				|| (next_state == ST_RISE) || (next_state == ST_DIR)
				|| (next_state == ST_STRISE)
				|| (next_state == ST_HOLD && op == OP_STORE);
		end
	end

	// direction changes only after the strobe has been high a while
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			o_ud <= 1'b0;
		else if (next_state == ST_DIR)
			o_ud <= up;
	end

	// ------------------------------------------------------------------
	// session flag, steps, handshake
	// ------------------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			o_selected <= 1'b0;
		else if (next_state == ST_SEL)
			o_selected <= 1'b1;
		else if (next_state == ST_HOLD)
			o_selected <= 1'b0;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			steps_left <= '0;
		else if (accept)
			steps_left <= (i_cmd_op == OP_MOVE) ? i_cmd_steps : '0;
		else if (next_state == ST_FALL && state != ST_FALL)
			steps_left <= steps_left - 1'b1;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			o_cmd_ready <= 1'b0;
			o_done      <= 1'b0;
		end
		else
		begin
			o_cmd_ready <= (next_state == ST_IDLE) && !accept;
			o_done      <= (next_state == ST_IDLE) && ((state != ST_IDLE) || accept);
		end
	end

	// ------------------------------------------------------------------
	// shadow of the device tap counter
	// ------------------------------------------------------------------
	// the device recalls an unknown stored value; this shadow is only
	// exact after a full-range move has pinned the wiper at an end
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			o_position <= POS_RESET;
		else if (next_state == ST_FALL && state != ST_FALL && !o_cs_n)
		begin
			if (up && o_position != POS_MAX)
				o_position <= o_position + 1'b1;
			else if (!up && o_position != '0)
				o_position <= o_position - 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	dcpc_cnt_t inc_age;
	dcpc_cnt_t ud_age;
	dcpc_cnt_t desel_age;
	logic      last_store;

	// cycles since strobe and direction last moved and since select last rose, saturating
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			inc_age    <= '0;
			ud_age     <= '0;
			desel_age  <= '0;
			last_store <= 1'b0;
		end
		else
		begin
			inc_age   <= (o_inc_n != $past(o_inc_n)) ? '0 : inc_age + (inc_age != '1);
			ud_age    <= (o_ud != $past(o_ud)) ? '0 : ud_age + (ud_age != '1);
			desel_age <= (o_cs_n && !$past(o_cs_n)) ? '0 : desel_age + (desel_age != '1);
			if (o_cs_n && !$past(o_cs_n))
				last_store <= o_inc_n;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	sequence s_step_fall;
		$fell(o_inc_n) && !o_cs_n;
	endsequence

	sequence s_store_exit;
		$rose(o_cs_n) && o_inc_n;
	endsequence

	property p_ic_gap;
		$rose(o_cs_n) |-> inc_age >= IC_CYC;
	endproperty
	a_ic_gap: assert property (p_ic_gap)
		else $error("select raised too soon after strobe settled");

	property p_store_hold;
		$fell(o_cs_n) && last_store |-> desel_age >= CNT_W'(STORE_HOLD_CYC);
	endproperty
	a_store_hold: assert property (p_store_hold)
		else $error("reselected before store cycle ended");

	property p_nostore_hold;
		$fell(o_cs_n) && !last_store |-> desel_age >= CPHNS_CYC;
	endproperty
	a_nostore_hold: assert property (p_nostore_hold)
		else $error("reselected too soon after release");

	property p_dir_setup;
		s_step_fall |-> $stable(o_ud) && ud_age >= DI_CYC;
	endproperty
	a_dir_setup: assert property (p_dir_setup)
		else $error("direction not settled before strobe fall");

	property p_step_move;
		s_step_fall |-> o_position == ($past(o_ud)
			? (($past(o_position) == POS_MAX) ? POS_MAX : $past(o_position) + 7'h01)
			: (($past(o_position) == '0) ? 7'h00 : $past(o_position) - 7'h01));
	endproperty
	a_step_move: assert property (p_step_move)
		else $error("shadow position did not follow a step");

	property p_range;
		o_position <= POS_MAX;
	endproperty
	a_range: assert property (p_range)
		else $error("shadow position beyond top tap");

	property p_no_desel_step;
		$fell(o_inc_n) && o_cs_n |-> $stable(o_position);
	endproperty
	a_no_desel_step: assert property (p_no_desel_step)
		else $error("position moved while deselected");

	property p_store_quiet;
		s_store_exit |=> (o_cs_n && o_inc_n) [*8];
	endproperty
	a_store_quiet: assert property (p_store_quiet)
		else $error("pins moved during store cycle");

	property p_powerup;
		$fell(i_rst) |-> (o_cs_n && o_inc_n && !o_cmd_ready) [*8];
	endproperty
	a_powerup: assert property (@(posedge i_mclk) p_powerup)
		else $error("pins or ready wrong right after reset");
endmodule

//--- core/dcpc_timer.sv
// down-counting wait timer used by the pin sequencer
// assumes load comes from logic on the same clock
`timescale 1ns/1ps
module dcpc_timer
	import dcpc_pkg::*;
(
	input  wire logic i_mclk,
	input  wire logic i_rst,
	dcpc_tmr_if.tmr   tmr
);
	dcpc_cnt_t cnt;

	// ------------------------------------------------------------------
	// count
	// ------------------------------------------------------------------
	// a load of n gives n+1 cycles before done, never shorter than asked
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			cnt <= '0;
		else if (tmr.load)
			cnt <= tmr.count;
		else if (cnt != '0)
			cnt <= cnt - 1'b1;
	end

	assign tmr.done = (cnt == '0);
endmodule

//--- tb/dcpc_host_test.sv
// self-checking bench for the potentiometer host controller
// assumes the device model of dcpc_pot_model and a 100 MHz clock
`timescale 1ns/1ps
module dcpc_host_test;
	import dcpc_pkg::*;

	localparam int        LIMIT = 90000; // whole run needs about 51000 cycles
	localparam dcpc_pos_t NV0   = 7'h2A;

	logic        i_mclk = 1'b0;
	logic        i_rst = 1'b1;
	logic        cmd_valid = 1'b0;
	dcpc_op_e    cmd_op = OP_MOVE;
	logic        cmd_up = 1'b0;
	dcpc_pos_t   cmd_steps = 7'h00;
	logic        o_cmd_ready;
	logic        o_done;
	logic        o_selected;
	dcpc_pos_t   o_position;
	logic        o_cs_n;
	logic        o_inc_n;
	logic        o_ud;
	dcpc_pos_t   dev_pos;
	dcpc_pos_t   dev_nv;
	logic [99:0] tap;
	int          stores;
	int          viol;
	int          dev = NV0;
	int          nv = NV0;
	int          shadow = 0;
	int          n_store = 0;
	int          err_total = 0;
	int          compares = 0;
	int          cycles = 0;
	logic [7:0]  lfsr = 8'h46;

	dcpc_host #(.STORE_HOLD_CYC(50)) i_dcpc_host (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_up(cmd_up),
		.i_cmd_steps(cmd_steps), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
		.o_selected(o_selected), .o_position(o_position), .o_cs_n(o_cs_n),
		.o_inc_n(o_inc_n), .o_ud(o_ud));
	dcpc_pot_model #(.NV_INIT(NV0)) i_dcpc_pot_model (.i_pwr_ok(!i_rst), .i_cs_n(o_cs_n),
		.i_inc_n(o_inc_n), .i_ud(o_ud), .o_pos(dev_pos), .o_nv(dev_nv), .o_tap(tap),
		.o_stores(stores), .o_viol(viol));

	always #5 i_mclk = ~i_mclk;

	// ------------------------------------------------------------------
	// verdict, compares and stimulus helpers
	// ------------------------------------------------------------------
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk_pos(input string what, input dcpc_pos_t exp, input dcpc_pos_t got);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic chk_pin(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk_cnt(input string what, input int exp, input int got);
		compares++;
		if (got != exp)
		begin
			err_total++;
			$display("wrong value %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// reset stands in for a power cycle of the whole board
	task automatic power_cycle();
		@(posedge i_mclk);
		i_rst <= 1'b1;
		@(posedge i_mclk);
		#1;
		chk_pin("select in reset", 1'b1, o_cs_n);
		chk_pin("strobe in reset", 1'b1, o_inc_n);
		@(posedge i_mclk);
		i_rst <= 1'b0;
		shadow = 0;
		dev = nv;
		while (o_cmd_ready !== 1'b1)
			@(posedge i_mclk);
		chk_pos("recalled wiper", dcpc_pos_t'(dev), dev_pos);
	endtask

	// one command; the global cycle ceiling bounds both waits
	task automatic run(input dcpc_op_e op, input logic up, input dcpc_pos_t steps);
		@(posedge i_mclk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_up <= up;
		cmd_steps <= steps;
		#1;
		while (o_cmd_ready !== 1'b1)
		begin
			@(posedge i_mclk);
			#1;
		end
		@(posedge i_mclk);
		cmd_valid <= 1'b0;
		#1;
		while (o_done !== 1'b1)
		begin
			@(posedge i_mclk);
			#1;
		end
		for (int k = 0; op == OP_MOVE && k < steps; k++)
		begin
			dev = up ? ((dev < 99) ? dev + 1 : 99) : ((dev > 0) ? dev - 1 : 0);
			shadow = up ? ((shadow < 99) ? shadow + 1 : 99) : ((shadow > 0) ? shadow - 1 : 0);
		end
		if (op == OP_STORE)
		begin
			nv = dev;
			n_store++;
		end
		chk_pos("host shadow", dcpc_pos_t'(shadow), o_position);
		chk_pos("wiper", dcpc_pos_t'(dev), dev_pos);
		chk_pin("one tap", 1'b1, $onehot(tap) && tap[dev]);
		chk_pin("select pin", op != OP_MOVE, o_cs_n);
		chk_pin("session", op == OP_MOVE, o_selected);
		chk_pos("stored", dcpc_pos_t'(nv), dev_nv);
		chk_cnt("store count", n_store, stores);
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial
	begin
		power_cycle();
		run(OP_RELEASE, 1'b0, 7'h00);
		run(OP_MOVE, 1'b0, 7'h63);
		run(OP_MOVE, 1'b1, 7'h00);
		for (int i = 0; i < 6; i++)
		begin
			lfsr = lfsr_next(lfsr);
			run(OP_MOVE, lfsr[7], {3'h0, lfsr[3:0]});
		end
		run(OP_STORE, 1'b0, 7'h00);
		run(OP_MOVE, 1'b1, 7'h63);
		run(OP_RELEASE, 1'b0, 7'h00);
		power_cycle();
		chk_cnt("pin timing faults", 0, viol);
		print_verdict();
	end

	// cycle ceiling cuts a hang short
	always @(posedge i_mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			err_total++;
			print_verdict();
		end
	end
endmodule

//--- tb/dcpc_pot_model.sv
// behavioural model of the up/down potentiometer control section
// assumes the host drives select, strobe and direction as plain pins
`timescale 1ns/1ps
module dcpc_pot_model #(
	parameter dcpc_pkg::dcpc_pos_t NV_INIT       = 7'h2A,  // arbitrary stored start value
	parameter real                 STORE_NS      = 400.0,  // shortened save cycle
	parameter real                 SAVE_DESEL_NS = 500.0,  // shortened hold after a save
	parameter real                 SETTLE_NS     = 1000.0
) (
	input  wire logic          i_pwr_ok,
	input  wire logic          i_cs_n,
	input  wire logic          i_inc_n,
	input  wire logic          i_ud,
	output dcpc_pkg::dcpc_pos_t o_pos,
	output dcpc_pkg::dcpc_pos_t o_nv,
	output logic [99:0]        o_tap,
	output int                 o_stores,
	output int                 o_viol
);
	import dcpc_pkg::*;

	real       t_desel;
	real       t_inc;
	logic      saved;
	logic      storing;
	logic      standby;
	dcpc_pos_t snap;

	// ------------------------------------------------------------------
	// start-up state
	// ------------------------------------------------------------------
	initial
	begin
		o_nv = NV_INIT;
		o_pos = NV_INIT;
		o_tap = 100'h1 << NV_INIT;
		o_stores = 0;
		o_viol = 0;
		t_desel = -1.0e9;
		t_inc = -1.0e9;
		storing = 1'b0;
		standby = 1'b0;
	end

	// supply back: recall, and both control pins must already be idle high
	always @(posedge i_pwr_ok)
	begin
		o_pos = o_nv;
		if (!(i_cs_n && i_inc_n))
			o_viol = o_viol + 1;
	end

	// strobe fall while selected moves one place, clamped rather than wrapped
	// an unpowered part neither steps nor saves
	always @(negedge i_inc_n)
	begin
		t_inc = $realtime;
		if (i_pwr_ok === 1'b1 && !i_cs_n && !storing && !standby)
		begin
			if (i_ud && o_pos < POS_MAX)
				o_pos = o_pos + 7'h01;
			else if (!i_ud && o_pos > 7'h00)
				o_pos = o_pos - 7'h01;
		end
	end
	always @(posedge i_inc_n)
		t_inc = $realtime;

	// new tap closes before the old opens, so taps overlap for a while
	always @(o_pos)
	begin
		o_tap = o_tap | (100'h1 << o_pos);
		#(SETTLE_NS) o_tap = 100'h1 << o_pos;
	end

	// select fall: deselect time depends on whether a save was started
	always @(negedge i_cs_n)
	begin
		if (saved === 1'b1 && $realtime - t_desel < SAVE_DESEL_NS)
			o_viol = o_viol + 1;
		if (saved === 1'b0 && $realtime - t_desel < 100.0)
			o_viol = o_viol + 1;
		standby = 1'b0;
	end

	// select rise with strobe high saves the value held at this instant;
	// the first pin edges out of reset come while unpowered and are not a save
	always @(posedge i_cs_n)
	begin
		if (i_pwr_ok === 1'b1)
		begin
			if ($realtime - t_inc < 1000.0)
				o_viol = o_viol + 1;
			t_desel = $realtime;
			saved = i_inc_n;
			if (i_inc_n === 1'b1)
			begin
				snap = o_pos;
				storing = 1'b1;
				#(STORE_NS) o_nv = snap;
				storing = 1'b0;
				standby = 1'b1;
				o_stores = o_stores + 1;
			end
		end
	end
endmodule
